// ==== lsu_pkg.sv ====
// Package for the integer load/store unit: bus layout, op encodings, constants.
// Assumes a 32-bit core with a 64-bit single-beat system bus.
package lsu_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int GPR_W  = 5;

  // Register map, byte offsets on the Wishbone bus
  localparam logic [7:0] CFG_OFS    = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] RESV_OFS   = 8'h08;
  localparam logic [7:0] GCNT_OFS   = 8'h0c;

  localparam int CFG_GATHER_BIT = 0;
  localparam int CFG_LE_BIT     = 1;
  localparam logic [1:0] CFG_RESET = 2'h0;

  // Reservation granule is 32 bytes
  localparam int RESV_LSB = 5;

  // Access sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  // Address generation modes
  typedef enum logic [1:0] {
    EA_REG_IMM = 2'h0,
    EA_REG_IDX = 2'h1,
    EA_REG     = 2'h2
  } ea_mode_e;

  // Op kinds
  typedef enum logic [2:0] {
    OP_LOAD   = 3'h0,
    OP_STORE  = 3'h1,
    OP_LWARX  = 3'h2,
    OP_STWCX  = 3'h3,
    OP_ECOWX  = 3'h4,
    OP_BARRIER = 3'h5
  } op_kind_e;

  typedef struct packed {
    op_kind_e          kind;
    ea_mode_e          mode;
    logic [1:0]        size;
    logic              sign_ext;
    logic              update;
    logic              byte_rev;
    logic              record;
    logic [GPR_W-1:0]  target_gpr;
    logic [GPR_W-1:0]  base_gpr;
    logic [DATA_W-1:0] base_val;
    logic [DATA_W-1:0] index_val;
    logic [15:0]       disp;
    logic [DATA_W-1:0] store_val;
    logic              cacheable;
    logic              write_thru;
    logic              guarded;
    logic              table_search;
  } lsu_req_s;

  typedef struct packed {
    logic              we;
    logic [GPR_W-1:0]  gpr;
    logic [DATA_W-1:0] val;
  } gpr_wr_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [63:0]       data;
    logic [7:0]        be;
    logic              we;
    logic              coherent;
    logic              ifetch;
  } bus_req_s;

endpackage : lsu_pkg

// ==== integer_load_store_unit.sv ====
// Integer load/store unit: address generation, loads, stores, reservation,
// store gathering, fetch port. Assumes bus/cache acks arrive on CLK domain.
// Contract
// RULE1: Fetch reads memory, bypassing data cache
// RULE2: Fetch bus requests never signal coherence
// RULE3: EA from reg+imm, reg+index, or reg
// RULE4: Load writes byte/half/word into target
// RULE5: Zero-extend loads; algebraic half sign-extends
// RULE6: Valid update load writes EA to base
// RULE7: Software avoids invalid update-load forms
// RULE8: Sign-extending loads take no extra cycles
// RULE9: Byte-reversed accesses keep normal latency
// RULE10: Reservation covers aligned 32-byte block
// RULE11: Write-through attribute never faults reserve ops
// RULE12: Conditional store always goes to bus
// RULE13: Store writes source data at EA
// RULE14: Update store writes EA after data; gathered stores write no EA to the base
// RULE15: Software avoids invalid store forms
// RULE16: Gather only aligned word, nonguarded WT/CI
// RULE17: Two gathered words form one beat
// RULE18: Gather only with pending qualifying successor
// RULE19: Gather ascending or descending addresses
// RULE20: Gather only when enable bit set
// RULE21: Never gather excluded store kinds
// RULE22: Barrier prevents gathering across it
`timescale 1ns/1ns
`default_nettype none
module integer_load_store_unit
  import lsu_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RESET,
  input  wire logic              CE,
  input  wire logic              REQ_VALID,
  output logic                   REQ_READY,
  input  wire lsu_req_s          REQ,
  output gpr_wr_s                GPR_WR0,
  output gpr_wr_s                GPR_WR1,
  output logic                   DSI,
  output logic                   CR0_EQ,
  output logic                   CR0_VALID,
  input  wire logic              FETCH_REQ,
  input  wire logic [ADDR_W-1:0] FETCH_ADDR,
  output logic [DATA_W-1:0]      FETCH_DATA,
  output logic                   FETCH_DONE,
  output logic                   BUS_VALID,
  output bus_req_s               BUS,
  input  wire logic              BUS_ACK,
  input  wire logic [63:0]       BUS_RDATA,
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [7:0]        WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [31:0]       WB_DAT_I,
  output logic [31:0]            WB_DAT_O,
  output logic                   WB_ACK_O
);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_BUS   = 2'b01,
    ST_WAIT2 = 2'b11
  } st_e;

  st_e               state_q;
  lsu_req_s          cur_q;
  logic [ADDR_W-1:0] ea_q;
  logic              fetch_q;
  logic [1:0]        cfg_q;
  logic              resv_valid_q;
  logic [ADDR_W-RESV_LSB-1:0] resv_blk_q;
  logic [15:0]       gather_cnt_q;
  logic              gathered_q;
  logic              stwcx_ok_q;

  // Address generation
  logic [ADDR_W-1:0] ea;
  always_comb begin
    case (REQ.mode)
      EA_REG_IMM: ea = REQ.base_val + {{16{REQ.disp[15]}}, REQ.disp}; // [RULE3]
      EA_REG_IDX: ea = REQ.base_val + REQ.index_val; // [RULE3]
      default:    ea = REQ.base_val; // [RULE3]
    endcase
  end

  // Gather qualification for one store
  function automatic logic qualifies(input lsu_req_s r, input logic [ADDR_W-1:0] a);
    qualifies = (r.kind == OP_STORE) && (r.size == SZ_WORD) && (a[1:0] == 2'h0) // [RULE16]
                && !r.guarded && (r.write_thru || !r.cacheable) // [RULE16]
                && !(r.cacheable && !r.write_thru) && !r.byte_rev && !r.table_search; // [RULE21]
  endfunction : qualifies

  // Pending slot: a qualifying store waits one cycle for a partner
  logic              pend_q;
  lsu_req_s          pend_r_q;
  logic [ADDR_W-1:0] pend_ea_q;

  wire accept = CE && REQ_VALID && REQ_READY;
  wire gather_en = cfg_q[CFG_GATHER_BIT];
  wire req_qual = qualifies(REQ, ea);
  wire pair_hit = pend_q && req_qual && gather_en && (REQ.kind != OP_BARRIER)
                  && (pend_ea_q[ADDR_W-1:3] == ea[ADDR_W-1:3])
                  && (pend_ea_q[2] != ea[2]); // [RULE19]

  // Held store without a partner goes out first; a new request must wait, not be lost
  assign REQ_READY = (state_q == ST_IDLE) && !fetch_q && !(pend_q && !pair_hit); // [RULE18]

  // Load data extraction
  function automatic logic [DATA_W-1:0] extract(input logic [63:0] d, input logic [ADDR_W-1:0] a,
                                                input logic [1:0] sz, input logic sx);
    logic [31:0] w;
    logic [15:0] h;
    logic [7:0]  b;
    w = a[2] ? d[31:0] : d[63:32];
    h = a[1] ? w[15:0] : w[31:16];
    b = a[0] ? h[7:0] : h[15:8];
    case (sz)
      SZ_BYTE: extract = {24'h000000, b}; // [RULE5]
      SZ_HALF: extract = sx ? {{16{h[15]}}, h} : {16'h0000, h}; // [RULE5]
      default: extract = w; // [RULE4]
    endcase
  endfunction : extract

  function automatic logic [7:0] lanes(input logic [ADDR_W-1:0] a, input logic [1:0] sz);
    case (sz)
      SZ_BYTE: lanes = 8'h80 >> a[2:0];
      SZ_HALF: lanes = 8'hc0 >> {a[2:1], 1'b0};
      default: lanes = 8'hf0 >> {a[2], 2'h0};
    endcase
  endfunction : lanes

  function automatic logic [63:0] place(input logic [DATA_W-1:0] v, input logic [ADDR_W-1:0] a,
                                        input logic [1:0] sz);
    logic [63:0] rep;
    case (sz)
      SZ_BYTE: rep = {8{v[7:0]}};
      SZ_HALF: rep = {4{v[15:0]}};
      default: rep = {2{v}};
    endcase
    place = rep; // [RULE13]
  endfunction : place

  wire [DATA_W-1:0] sdata = REQ.byte_rev ? {REQ.store_val[7:0], REQ.store_val[15:8],
                            REQ.store_val[23:16], REQ.store_val[31:24]} >> (REQ.size == SZ_HALF ? 16 : 0)
                            : REQ.store_val; // [RULE9]

  // Main sequencer and bus request
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_q   <= ST_IDLE;
      BUS_VALID <= 1'b0;
      BUS       <= '0;
      cur_q     <= '0;
      ea_q      <= '0;
      pend_q    <= 1'b0;
      pend_r_q  <= '0;
      pend_ea_q <= '0;
      gathered_q <= 1'b0;
    end else if (CE) begin
      case (state_q)
        ST_IDLE: begin
          gathered_q <= 1'b0;
          if (accept && pair_hit) begin
            // Merge into one double word, address order irrelevant
            BUS_VALID     <= 1'b1;
            BUS.addr      <= {ea[ADDR_W-1:3], 3'h0};
            BUS.data      <= ea[2] ? {pend_r_q.store_val, REQ.store_val}
                                   : {REQ.store_val, pend_r_q.store_val}; // [RULE17]
            BUS.be        <= 8'hff; // [RULE17]
            BUS.we        <= 1'b1;
            BUS.coherent  <= 1'b0;
            BUS.ifetch    <= 1'b0;
            cur_q         <= REQ;
            ea_q          <= ea;
            pend_q        <= 1'b0;
            gathered_q    <= 1'b1;
            state_q       <= ST_BUS;
          end else if (pend_q) begin
            // No partner this cycle: issue the held store alone
            BUS_VALID    <= 1'b1;
            BUS.addr     <= pend_ea_q;
            BUS.data     <= place(pend_r_q.store_val, pend_ea_q, SZ_WORD);
            BUS.be       <= lanes(pend_ea_q, SZ_WORD);
            BUS.we       <= 1'b1;
            BUS.coherent <= 1'b0;
            BUS.ifetch   <= 1'b0;
            cur_q        <= pend_r_q;
            ea_q         <= pend_ea_q;
            pend_q       <= 1'b0; // [RULE18]
            state_q      <= ST_BUS;
          end else if (accept && REQ.kind == OP_BARRIER) begin
            state_q <= ST_IDLE; // [RULE22]
          end else if (accept && req_qual && gather_en) begin
            pend_q    <= 1'b1;
            pend_r_q  <= REQ;
            pend_ea_q <= ea;
          end else if (accept) begin
            BUS_VALID    <= 1'b1;
            BUS.addr     <= ea;
            BUS.data     <= place(sdata, ea, REQ.size);
            BUS.be       <= lanes(ea, REQ.size);
            BUS.we       <= (REQ.kind != OP_LOAD) && (REQ.kind != OP_LWARX); // [RULE12]
            BUS.coherent <= REQ.cacheable;
            BUS.ifetch   <= 1'b0;
            cur_q        <= REQ;
            ea_q         <= ea;
            state_q      <= ST_BUS;
          end else if (fetch_q) begin
            BUS_VALID    <= 1'b1;
            BUS.addr     <= FETCH_ADDR;
            BUS.we       <= 1'b0;
            BUS.be       <= 8'hff;
            BUS.coherent <= 1'b0; // [RULE2]
            BUS.ifetch   <= 1'b1; // [RULE1]
            state_q      <= ST_BUS;
          end
        end
        ST_BUS: begin
          if (BUS_ACK) begin
            BUS_VALID <= 1'b0;
            state_q   <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Fetch latch; served directly from memory, never from data cache
  always_ff @(posedge CLK) begin
    if (RESET) begin
      fetch_q    <= 1'b0;
      FETCH_DATA <= '0;
      FETCH_DONE <= 1'b0;
    end else if (CE) begin
      FETCH_DONE <= 1'b0;
      if (FETCH_REQ && !fetch_q)
        fetch_q <= 1'b1;
      if (state_q == ST_BUS && BUS_ACK && BUS.ifetch) begin
        FETCH_DATA <= BUS.addr[2] ? BUS_RDATA[31:0] : BUS_RDATA[63:32]; // [RULE1]
        FETCH_DONE <= 1'b1;
        fetch_q    <= 1'b0;
      end
    end
  end

  wire done = CE && (state_q == ST_BUS) && BUS_ACK && !BUS.ifetch;
  wire resv_hit = resv_valid_q && (resv_blk_q == ea_q[ADDR_W-1:RESV_LSB]);

  // Register write-back, same cycle count for all load kinds
  always_ff @(posedge CLK) begin
    if (RESET) begin
      GPR_WR0   <= '0;
      GPR_WR1   <= '0;
      CR0_EQ    <= 1'b0;
      CR0_VALID <= 1'b0;
      DSI       <= 1'b0;
    end else if (CE) begin
      GPR_WR0   <= '0;
      GPR_WR1   <= '0;
      CR0_VALID <= 1'b0;
      DSI       <= 1'b0;
      if (done) begin
        if (cur_q.kind == OP_LOAD || cur_q.kind == OP_LWARX) begin
          GPR_WR0.we  <= 1'b1;
          GPR_WR0.gpr <= cur_q.target_gpr;
          GPR_WR0.val <= extract(BUS_RDATA, ea_q, cur_q.size, cur_q.sign_ext); // [RULE4] [RULE8]
          if (cur_q.update && cur_q.base_gpr != '0 && cur_q.base_gpr != cur_q.target_gpr) begin
            GPR_WR1.we  <= 1'b1; // [RULE6]
            GPR_WR1.gpr <= cur_q.base_gpr;
            GPR_WR1.val <= ea_q;
          end
        end else if (cur_q.update && cur_q.base_gpr != '0 && !gathered_q) begin
          // Store data already left with the request; EA lands afterwards
          GPR_WR1.we  <= 1'b1; // [RULE14]
          GPR_WR1.gpr <= cur_q.base_gpr;
          GPR_WR1.val <= ea_q;
        end
        if (cur_q.kind == OP_STWCX) begin
          CR0_VALID <= 1'b1;
          CR0_EQ    <= stwcx_ok_q;
        end
        // Write-through alone never faults a reserve op
        DSI <= 1'b0; // [RULE11]
      end
    end
  end

  // Reservation tracking
  always_ff @(posedge CLK) begin
    if (RESET) begin
      resv_valid_q <= 1'b0;
      resv_blk_q   <= '0;
      stwcx_ok_q   <= 1'b0;
    end else if (CE) begin
      if (accept && REQ.kind == OP_STWCX)
        stwcx_ok_q <= resv_valid_q && (resv_blk_q == ea[ADDR_W-1:RESV_LSB]); // [RULE10]
      if (done && cur_q.kind == OP_LWARX) begin
        resv_valid_q <= 1'b1;
        resv_blk_q   <= ea_q[ADDR_W-1:RESV_LSB]; // [RULE10]
      end else if (done && cur_q.kind == OP_STWCX) begin
        resv_valid_q <= 1'b0;
      end else if (done && BUS.we && resv_hit) begin
        resv_valid_q <= 1'b0;
      end
    end
  end

  // Wishbone slave: one-cycle ack
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cfg_q        <= CFG_RESET;
      WB_ACK_O     <= 1'b0;
      WB_DAT_O     <= '0;
      gather_cnt_q <= '0;
    end else if (CE) begin
      WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
      if (done && gathered_q)
        gather_cnt_q <= gather_cnt_q + 16'h0001;
      if (WB_CYC_I && WB_STB_I && !WB_ACK_O) begin
        if (WB_WE_I && WB_ADR_I == CFG_OFS && WB_SEL_I[0])
          cfg_q <= WB_DAT_I[1:0]; // [RULE20]
        case (WB_ADR_I)
          CFG_OFS:    WB_DAT_O <= {30'h0, cfg_q};
          STATUS_OFS: WB_DAT_O <= {28'h0, pend_q, fetch_q, state_q};
          RESV_OFS:   WB_DAT_O <= {resv_blk_q, 4'h0, resv_valid_q};
          GCNT_OFS:   WB_DAT_O <= {16'h0, gather_cnt_q};
          default:    WB_DAT_O <= 32'h0;
        endcase
      end
    end
  end

  AST_FETCH_NONCOH: assert property (@(posedge CLK) disable iff (RESET)
    BUS_VALID && BUS.ifetch |-> !BUS.coherent) else $error("fetch coherent"); // [RULE2]
  AST_GATHER_BEAT: assert property (@(posedge CLK) disable iff (RESET)
    CE && state_q == ST_IDLE && accept && pair_hit |=> BUS_VALID && BUS.be == 8'hff) else $error("gather beat"); // [RULE17]
  AST_GATHER_EN: assert property (@(posedge CLK) disable iff (RESET)
    CE && !gather_en && accept |=> !(BUS_VALID && BUS.we && BUS.be == 8'hff)) else $error("gather disabled"); // [RULE20]
  AST_PEND_ALONE: assert property (@(posedge CLK) disable iff (RESET)
    CE && state_q == ST_IDLE && pend_q && !(accept && pair_hit) |=> BUS_VALID && !gathered_q) else $error("pend"); // [RULE18]
  AST_NO_BARRIER: assert property (@(posedge CLK) disable iff (RESET)
    CE && accept && REQ.kind == OP_BARRIER |=> !pend_q && !gathered_q) else $error("barrier gather"); // [RULE22]
  AST_EXCLUDE: assert property (@(posedge CLK) disable iff (RESET)
    pair_hit |-> !REQ.guarded && !REQ.byte_rev && REQ.kind == OP_STORE) else $error("excluded"); // [RULE21]
  AST_STWCX_BUS: assert property (@(posedge CLK) disable iff (RESET)
    CE && accept && REQ.kind == OP_STWCX |=> BUS_VALID && BUS.we) else $error("stwcx bus"); // [RULE12]
  AST_UPD_LOAD: assert property (@(posedge CLK) disable iff (RESET)
    done && cur_q.kind == OP_LOAD && cur_q.update && cur_q.base_gpr != '0
    && cur_q.base_gpr != cur_q.target_gpr |=> GPR_WR1.we && GPR_WR1.val == $past(ea_q)) else $error("upd"); // [RULE6]
  AST_NO_DSI: assert property (@(posedge CLK) disable iff (RESET) !DSI) else $error("dsi"); // [RULE11]

  COV_GATHER: cover property (@(posedge CLK) disable iff (RESET) accept && pair_hit);
  COV_FETCH:  cover property (@(posedge CLK) disable iff (RESET) FETCH_DONE);
  COV_STWCX:  cover property (@(posedge CLK) disable iff (RESET) CR0_VALID);

endmodule : integer_load_store_unit
`default_nettype wire

// ==== bus_partner.sv ====
// Far-side system bus model: acks after a set delay, returns address pattern.
// Assumes one outstanding request, held valid until acked.
`timescale 1ns/1ns
`default_nettype none
module bus_partner
  import lsu_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] dly,
  input  wire logic       valid,
  input  wire bus_req_s   req,
  output logic            ack,
  output logic [63:0]     rdata
);
  logic [3:0] cnt_q;

  // Memory seen only as a pattern of the address, no cache in front
  always_ff @(posedge clk) begin
    if (rst) begin
      ack   <= 1'b0;
      cnt_q <= 4'h0;
      rdata <= 64'h0;
    end else if (valid && !ack && cnt_q >= dly) begin
      ack   <= 1'b1;
      cnt_q <= 4'h0;
      rdata <= {8{req.addr[7:0] | 8'h80}};
    end else begin
      ack   <= 1'b0;
      cnt_q <= (valid && !ack) ? cnt_q + 4'h1 : 4'h0;
      // Toggling idle data, so a stale sample never matches
      rdata <= ~rdata;
    end
  end
endmodule : bus_partner
`default_nettype wire

// ==== testbench.sv ====
// Testbench: op requests, fetches and Wishbone register calls with expected values.
// Assumes bus_partner on the system bus side; CE and byte selects tied.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import lsu_pkg::*;
  logic        CLK = 1'b0;
  logic        RESET = 1'b1;
  logic        REQ_VALID = 1'b0;
  logic        FETCH_REQ = 1'b0;
  logic [31:0] FETCH_ADDR = 32'h0;
  logic        WB_CYC_I = 1'b0;
  logic        WB_STB_I = 1'b0;
  logic        WB_WE_I = 1'b0;
  logic [7:0]  WB_ADR_I = 8'h0;
  logic [31:0] WB_DAT_I = 32'h0;
  logic [3:0]  dly = 4'h3;
  lsu_req_s    REQ = '0;
  logic        REQ_READY, DSI, CR0_EQ, CR0_VALID, FETCH_DONE, BUS_VALID, BUS_ACK, WB_ACK_O;
  gpr_wr_s     GPR_WR0, GPR_WR1, w0, w1;
  logic [31:0] FETCH_DATA, WB_DAT_O, q;
  logic [63:0] BUS_RDATA;
  bus_req_s    BUS, lb;
  lsu_req_s    r, a, b, bar;
  int          cyc = 0, ack_c = 0, wr0_c = 0, n_wr = 0, fails = 0, n_tests = 0, n0;
  logic        got0 = 1'b0, crg = 1'b0, cr = 1'b0;

  integer_load_store_unit dut_u (.CLK, .RESET, .CE(1'b1), .REQ_VALID, .REQ_READY, .REQ, .GPR_WR0, .GPR_WR1,
    .DSI, .CR0_EQ, .CR0_VALID, .FETCH_REQ, .FETCH_ADDR, .FETCH_DATA, .FETCH_DONE, .BUS_VALID, .BUS,
    .BUS_ACK, .BUS_RDATA, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I(4'hf), .WB_DAT_I,
    .WB_DAT_O, .WB_ACK_O);
  bus_partner far_u (.clk(CLK), .rst(RESET), .dly, .valid(BUS_VALID), .req(BUS), .ack(BUS_ACK),
    .rdata(BUS_RDATA));

  always #4 CLK = ~CLK;

  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (BUS_VALID && BUS_ACK) begin
      ack_c <= cyc;
      lb <= BUS;
      n_wr <= n_wr + int'(BUS.we);
    end
    if (GPR_WR0.we) begin
      w0 <= GPR_WR0;
      wr0_c <= cyc;
      got0 <= 1'b1;
    end
    if (GPR_WR1.we) w1 <= GPR_WR1;
    if (CR0_VALID) begin
      cr <= CR0_EQ;
      crg <= 1'b1;
    end
  end

  // Whole run is a few hundred cycles
  always @(posedge CLK) if (cyc == 20000) begin
    fails++;
    results();
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic lsu_req_s mk(op_kind_e k, logic [1:0] sz, logic [31:0] bv, logic [31:0] sv);
    lsu_req_s x;
    x = '0;
    x.kind = k;
    x.size = sz;
    x.mode = EA_REG;
    x.base_val = bv;
    x.store_val = sv;
    // Base 4 and target 3 keep update forms valid
    x.target_gpr = 5'h3;
    x.base_gpr = 5'h4;
    x.write_thru = 1'b1;
    return x;
  endfunction : mk

  function automatic lsu_req_s tw(lsu_req_s x, int i);
    case (i)
      0: x.write_thru = 1'b0;
      1: x.guarded = 1'b1;
      2: x.byte_rev = 1'b1;
      3: x.kind = OP_STWCX;
      4: x.kind = OP_ECOWX;
      5: x.table_search = 1'b1;
      default: x.size = SZ_HALF;
    endcase
    if (i == 0) x.cacheable = 1'b1;
    return x;
  endfunction : tw

  task automatic issue(input lsu_req_s x);
    REQ <= x;
    REQ_VALID <= 1'b1;
    @(posedge CLK);
    while (!REQ_READY) @(posedge CLK);
  endtask : issue

  task automatic idle();
    REQ_VALID <= 1'b0;
    @(posedge CLK);
  endtask : idle

  task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= ad;
    WB_DAT_I <= d;
    @(posedge CLK);
    while (!WB_ACK_O) @(posedge CLK);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge CLK);
  endtask : wb

  task automatic ld(input lsu_req_s x, input logic [31:0] ea, input logic [31:0] v);
    got0 = 1'b0;
    issue(x);
    idle();
    while (!got0) @(posedge CLK);
    chk(w0.val, v);
    chk(w0.gpr, x.target_gpr);
    chk(lb.addr[31:3], ea[31:3]);
    chk(wr0_c - ack_c, 1);
  endtask : ld

  task automatic sc(input logic [31:0] ea, input logic exp);
    crg = 1'b0;
    n0 = n_wr;
    r = mk(OP_STWCX, SZ_WORD, ea, 32'h5a);
    r.cacheable = 1'b1;
    issue(r);
    idle();
    while (!crg || n_wr == n0) @(posedge CLK);
    chk(cr, exp);
    chk(n_wr - n0, 1);
  endtask : sc

  // Stores a, optional barrier, b unless n is 0; counts bus writes that follow
  task automatic grp(input lsu_req_s x, input lsu_req_s y, input logic mid, input int n);
    n0 = n_wr;
    issue(x);
    if (mid) issue(bar);
    if (n > 0) issue(y);
    idle();
    while (n_wr == n0) @(posedge CLK);
    repeat (12) @(posedge CLK);
    chk(n_wr - n0, (n > 0) ? n : 1);
    if (n == 1) chk(lb.be, 8'hff);
    if (n == 1) chk(lb.data === {x.store_val, y.store_val} || lb.data === {y.store_val, x.store_val}, 1);
  endtask : grp

  initial begin
    bar = mk(OP_BARRIER, SZ_WORD, 32'h0, 32'h0);
    repeat (6) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    FETCH_ADDR <= 32'h0000_0124;
    FETCH_REQ <= 1'b1;
    @(posedge CLK);
    while (!FETCH_DONE) @(posedge CLK);
    FETCH_REQ <= 1'b0;
    chk(FETCH_DATA, 32'ha4a4_a4a4);
    chk({lb.ifetch, lb.coherent}, 2'h2);
    r = mk(OP_LOAD, SZ_BYTE, 32'h1000, 32'h0);
    r.mode = EA_REG_IMM;
    r.disp = 16'hfff1;
    ld(r, 32'h0ff1, 32'h0000_00f1);
    r = mk(OP_LOAD, SZ_HALF, 32'h1000, 32'h0);
    r.mode = EA_REG_IDX;
    r.index_val = 32'h22;
    r.sign_ext = 1'b1;
    ld(r, 32'h1022, 32'hffff_a2a2);
    r = mk(OP_LOAD, SZ_HALF, 32'h1046, 32'h0);
    r.update = 1'b1;
    ld(r, 32'h1046, 32'h0000_c6c6);
    chk({w1.gpr, w1.val}, {5'h4, 32'h1046});
    dly <= 4'h0;
    r = mk(OP_LOAD, SZ_WORD, 32'h1008, 32'h0);
    r.byte_rev = 1'b1;
    ld(r, 32'h1008, 32'h8888_8888);
    ld(mk(OP_LWARX, SZ_WORD, 32'h3000, 32'h0), 32'h3000, 32'h8080_8080);
    chk(DSI, 1'b0);
    sc(32'h301c, 1'b1);
    ld(mk(OP_LWARX, SZ_WORD, 32'h3000, 32'h0), 32'h3000, 32'h8080_8080);
    sc(32'h3020, 1'b0);
    r = mk(OP_STORE, SZ_WORD, 32'h4000, 32'h1234_5678);
    grp(r, r, 1'b0, 0);
    chk(lb.data, {2{32'h1234_5678}});
    chk({lb.we, lb.addr[31:2], 4'($countones(lb.be))}, {1'b1, 30'h1000, 4'h4});
    r = mk(OP_STORE, SZ_WORD, 32'h4010, 32'h4010);
    r.mode = EA_REG_IMM;
    r.disp = 16'h0008;
    r.target_gpr = 5'h4;
    r.update = 1'b1;
    grp(r, r, 1'b0, 0);
    chk(lb.data, {2{32'h4010}});
    chk({w1.gpr, w1.val}, {5'h4, 32'h4018});
    a = mk(OP_STORE, SZ_WORD, 32'h2000, 32'h1111_1111);
    b = mk(OP_STORE, SZ_WORD, 32'h2004, 32'h2222_2222);
    wb(1'b0, CFG_OFS, 32'h0);
    chk(q[1:0], CFG_RESET);
    grp(a, b, 1'b0, 2);
    wb(1'b1, CFG_OFS, 32'h1);
    wb(1'b0, CFG_OFS, 32'h0);
    chk(q[1:0], 2'h1);
    wb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0);
    grp(b, a, 1'b0, 1);
    grp(a, b, 1'b0, 1);
    grp(a, b, 1'b1, 2);
    grp(a, b, 1'b0, 0);
    chk(4'($countones(lb.be)), 4'h4);
    for (int i = 0; i < 7; i++) grp(tw(a, i), tw(b, i), 1'b0, 2);
    wb(1'b1, CFG_OFS, 32'h3);
    grp(a, b, 1'b0, 1);
    wb(1'b0, GCNT_OFS, 32'h0);
    chk(q, 32'h3);
    results();
  end
endmodule : testbench
`default_nettype wire
